// >>> hdl/led_latch_pkg.sv
package led_latch_pkg;
  // ----------------------------------------------------------------
  // latch geometry
  // ----------------------------------------------------------------
  localparam int SHIFT_W   = 257;   // common shift register
  localparam int SHIFT_MSB = 256;   // selects control or grayscale
  localparam int GS_W      = 256;   // grayscale latch width
  localparam int CTRL1_W   = 137;   // first control latch
  localparam int CTRL2_W   = 119;   // second control latch
  localparam int CH_N      = 16;    // sink outputs
  localparam int GS_BITS   = 16;    // grayscale bits per channel
  localparam int DC_W      = 112;   // dot correction total
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BRIGHT_LO  = 112;  // global brightness, 7 bits
  localparam int BRIGHT_W   = 7;
  localparam int BLANK_POS  = 119;  // outputs off
  localparam int RPT_POS    = 120;  // auto repeat
  localparam int RST_POS    = 121;  // timing restart
  localparam int SPREAD_POS = 122;  // pwm style
  localparam int OPEN_LO    = 123;  // open threshold, 2 bits
  localparam int SHORT_LO   = 125;  // short threshold, 2 bits
  localparam int SAMPLE_LO  = 127;  // fault sample timing, 2 bits
  localparam int INVISIBLE_CHECK_REPEAT_POS = 130;  // invisible check repeat
  localparam int PSAVE_LO   = 134;  // power save, 3 bits
  localparam int SEL_W      = 2;
  localparam int PSAVE_W    = 3;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [CTRL1_W-1:0] CTRL1_RESET =
    {3'h7, 14'h0000, 1'h1, 119'h0};  // power save 111, outputs off
  localparam logic [15:0] GS_LAST  = 16'hffff;  // 65536th clock
  localparam logic [15:0] GS_ZERO  = 16'h0000;
  localparam int          SEG_LO   = 9;         // spread segment split
  localparam int          SEG_W    = 7;
  localparam int          POS_W    = 9;
  localparam int          SYNC_N   = 3;
  // fault capture points per sample timing code
  localparam logic [15:0] CAPTURE_AT0 = 16'h0001;
  localparam logic [15:0] CAPTURE_AT1 = 16'h0400;
  localparam logic [15:0] CAPTURE_AT2 = 16'h1000;
  localparam logic [15:0] CAPTURE_AT3 = 16'h4000;
  // ----------------------------------------------------------------
  // display sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DISP_BLANK = 2'b00,
    DISP_RUN   = 2'b01,
    DISP_STOP  = 2'b10
  } disp_state_t;
endpackage : led_latch_pkg

// >>> hdl/led_driver_control_latch.sv
`timescale 1ns/10ps
// Behaviour
// - seven-bit global brightness at bits 118-112
// - brightness output taken from second latch
// - eighteen function control bits in first latch
// - outputs off: sinks off, counter cleared
// - outputs on: pwm controller drives sinks
// - no repeat: one display period then stop
// - repeat: restart every 65536 grayscale clocks
// - restart bit: grayscale write clears counter
// - restart bit clear: strobe leaves timing alone
// - after restart resume on next grayscale edge
// - style bit: conventional or spread pwm
// - two bits select open threshold
// - two bits select short threshold
// - two bits select fault capture moment
// - repeat without check repeat: capture once per second latch load
// - serial in shifts into lsb, msb-ward
// - strobe with msb set loads 137 bits
// - copy 119 bits at wrap, off or restart
module led_driver_control_latch
  import led_latch_pkg::*;
(
  input  wire logic              clock,               // system clock
  input  wire logic              sys_rst,             // async reset
  input  wire logic              shift_clock,         // serial shift clock
  input  wire logic              serial_in,           // serial data
  input  wire logic              load_strobe,         // latch pin
  input  wire logic              grayscale_clock,     // pwm clock pin
  output logic                   serial_out,          // shift msb
  output logic [CH_N-1:0]        sink_outputs,        // channel on
  output logic [BRIGHT_W-1:0]    global_brightness,   // active brightness
  output logic [DC_W-1:0]        dot_correction,      // active dot corr
  output logic                   spread_mode_sel,     // pwm style
  output logic [SEL_W-1:0]       open_threshold_sel,  // open threshold
  output logic [SEL_W-1:0]       short_threshold_sel, // short threshold
  output logic [SEL_W-1:0]       fault_sample_timing, // capture moment
  output logic [PSAVE_W-1:0]     power_save_sel,      // power save
  output logic                   fault_capture        // capture pulse
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SHIFT_W-1:0] shreg;  // common shift register
  } link_t;

  typedef struct packed {
    logic [SYNC_N-1:0]  lat_sync;  // strobe synchroniser
    logic [SYNC_N-1:0]  gsc_sync;  // grayscale clock synchroniser
    logic               lat_lvl;   // agreed strobe level
    logic               gsc_lvl;   // agreed grayscale clock level
    logic [CTRL1_W-1:0] ctrl1;     // first control latch
    logic [CTRL2_W-1:0] ctrl2;     // second control latch
    logic [GS_W-1:0]    gs1;       // first grayscale latch
    logic [GS_W-1:0]    gs2;       // second grayscale latch
    logic [15:0]        gs_cnt;    // grayscale counter
    disp_state_t        disp;      // display sequencer
    logic               fresh;     // new data awaiting capture
    logic [CH_N-1:0]    sink;      // registered sink drive
    logic               capture;   // capture pulse
  } core_t;

  link_t link_r;   // link domain state
  link_t link_nxt;
  core_t core_r;   // system domain state
  core_t core_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one channel on/off for the present count
  function automatic logic pwm_on(input logic [15:0] gs,
                                  input logic [15:0] cnt,
                                  input logic        spread);
    logic [SEG_W-1:0] seg_rev;
    seg_rev = '0;
    for (int i = 0; i < SEG_W; i++) begin
      seg_rev[i] = cnt[SEG_LO+SEG_W-1-i];
    end
    if (!spread) begin
      pwm_on = cnt < gs;  // one pulse per period
    end else begin
      // spread: 128 segments, remainder spread by reversed index
      pwm_on = (cnt[POS_W-1:0] < gs[15:SEG_W]) ||
               ((cnt[POS_W-1:0] == gs[15:SEG_W]) &&
                (seg_rev < gs[SEG_W-1:0]));
    end
  endfunction : pwm_on

  // capture point per sample timing code
  function automatic logic [15:0] capture_point(input logic [1:0] sel);
    case (sel)
      2'h0:    capture_point = CAPTURE_AT0;
      2'h1:    capture_point = CAPTURE_AT1;
      2'h2:    capture_point = CAPTURE_AT2;
      default: capture_point = CAPTURE_AT3;
    endcase
  endfunction : capture_point

  // ----------------------------------------------------------------
  // per-channel pwm compare
  // ----------------------------------------------------------------
  logic [CH_N-1:0] pwm_hit;  // compare result per channel

  generate
    for (genvar ch = 0; ch < CH_N; ch++) begin : g_chan
      // compare against second latch at current count
      assign pwm_hit[ch] = pwm_on(core_r.gs2[ch*GS_BITS +: GS_BITS],
                                  core_r.gs_cnt,
                                  core_r.ctrl1[SPREAD_POS]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic lat_rise;     // strobe rising, agreed
  logic gs_rise;      // grayscale clock rising, agreed
  logic ctrl_write;   // strobe with msb set
  logic gs_write;     // strobe with msb clear
  logic blank_on;     // outputs off bit
  logic restart_evt;  // timing restart taken
  logic wrap;         // 65536th grayscale clock
  logic once_only;    // capture once mode

  // strobe level changes once stages two and three agree
  assign lat_rise    = (core_r.lat_sync[1] == core_r.lat_sync[2]) &&
                       core_r.lat_sync[2] && !core_r.lat_lvl;
  assign gs_rise     = (core_r.gsc_sync[1] == core_r.gsc_sync[2]) &&
                       core_r.gsc_sync[2] && !core_r.gsc_lvl;
  // shift register is quiet while the strobe is high
  assign ctrl_write  = lat_rise && link_r.shreg[SHIFT_MSB];
  assign gs_write    = lat_rise && !link_r.shreg[SHIFT_MSB];
  assign blank_on    = core_r.ctrl1[BLANK_POS];
  assign restart_evt = !blank_on && gs_write &&
                       core_r.ctrl1[RST_POS];
  assign wrap        = core_r.disp == DISP_RUN && gs_rise &&
                       core_r.gs_cnt == GS_LAST;
  assign once_only   = core_r.ctrl1[RPT_POS] &&
                       !core_r.ctrl1[INVISIBLE_CHECK_REPEAT_POS];

  // ----------------------------------------------------------------
  // link domain: serial shift
  // ----------------------------------------------------------------
  // shift toward msb, new bit at lsb
  always_comb begin
    link_nxt       = link_r;
    link_nxt.shreg = {link_r.shreg[SHIFT_W-2:0], serial_in};
  end

  // link register
  always_ff @(posedge shift_clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------------------------------
  // system domain: latches, counter, outputs
  // ----------------------------------------------------------------
  always_comb begin
    core_nxt          = core_r;
    core_nxt.capture  = 1'b0;
    // pin synchronisers
    core_nxt.lat_sync = {core_r.lat_sync[1:0], load_strobe};
    core_nxt.gsc_sync = {core_r.gsc_sync[1:0], grayscale_clock};
    if (core_r.lat_sync[1] == core_r.lat_sync[2]) begin
      core_nxt.lat_lvl = core_r.lat_sync[2];
    end
    if (core_r.gsc_sync[1] == core_r.gsc_sync[2]) begin
      core_nxt.gsc_lvl = core_r.gsc_sync[2];
    end
    // first latch loads
    if (ctrl_write) begin
      core_nxt.ctrl1 = link_r.shreg[CTRL1_W-1:0];
    end
    if (gs_write) begin
      core_nxt.gs1 = link_r.shreg[GS_W-1:0];
    end
    if (blank_on) begin
      // outputs off: clear, reinit, refresh second latches
      core_nxt.gs_cnt = GS_ZERO;
      core_nxt.sink   = '0;
      core_nxt.disp   = DISP_BLANK;
      core_nxt.ctrl2  = core_r.ctrl1[CTRL2_W-1:0];
      core_nxt.gs2    = core_r.gs1;
      core_nxt.fresh  = 1'b1;
    end else if (restart_evt) begin
      // restart: counter cleared, new data in at once
      core_nxt.gs_cnt = GS_ZERO;
      core_nxt.sink   = '0;
      core_nxt.disp   = DISP_RUN;
      core_nxt.ctrl2  = core_r.ctrl1[CTRL2_W-1:0];
      core_nxt.gs2    = link_r.shreg[GS_W-1:0];
      core_nxt.fresh  = 1'b1;
    end else begin
      // strobe without restart leaves timing alone
      case (core_r.disp)
        DISP_BLANK: begin
          // outputs just enabled, count from zero
          core_nxt.disp = DISP_RUN;
        end
        DISP_RUN: begin
          if (gs_rise) begin
            core_nxt.sink = pwm_hit;
            // fault capture at the chosen count
            if (core_r.gs_cnt ==
                capture_point(core_r.ctrl1[SAMPLE_LO +: SEL_W]) &&
                (core_r.fresh || !once_only)) begin
              core_nxt.capture = 1'b1;
              core_nxt.fresh   = 1'b0;
            end
            if (wrap) begin
              core_nxt.gs_cnt = GS_ZERO;
              core_nxt.ctrl2  = core_r.ctrl1[CTRL2_W-1:0];
              if (core_r.ctrl1[RPT_POS]) begin
                core_nxt.gs2   = core_r.gs1;
                core_nxt.fresh = 1'b1;  // set wins over clear
              end else begin
                core_nxt.disp = DISP_STOP;
                core_nxt.sink = '0;
              end
            end else begin
              core_nxt.gs_cnt = core_r.gs_cnt + 16'h0001;
            end
          end
        end
        DISP_STOP: begin
          // period done, hold outputs off
          core_nxt.sink = '0;
        end
        default: begin
          core_nxt.disp = DISP_BLANK;
        end
      endcase
    end
  end

  // system register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_r       <= '0;
      core_r.ctrl1 <= CTRL1_RESET;  // outputs off at reset
      core_r.disp  <= DISP_BLANK;
    end else begin
      core_r <= core_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign serial_out          = link_r.shreg[SHIFT_MSB];
  assign sink_outputs        = core_r.sink;
  assign global_brightness   = core_r.ctrl2[BRIGHT_LO +: BRIGHT_W];
  assign dot_correction      = core_r.ctrl2[DC_W-1:0];
  assign spread_mode_sel     = core_r.ctrl1[SPREAD_POS];
  assign open_threshold_sel  = core_r.ctrl1[OPEN_LO +: SEL_W];
  assign short_threshold_sel = core_r.ctrl1[SHORT_LO +: SEL_W];
  assign fault_sample_timing = core_r.ctrl1[SAMPLE_LO +: SEL_W];
  assign power_save_sel      = core_r.ctrl1[PSAVE_LO +: PSAVE_W];
  assign fault_capture       = core_r.capture;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_restart;
    restart_evt;
  endsequence

  sequence s_cleared;
    core_r.gs_cnt == GS_ZERO && core_r.sink == '0;
  endsequence

  sequence s_first_edge;
    core_r.disp == DISP_RUN && core_r.gs_cnt == GS_ZERO && gs_rise &&
      !blank_on && !restart_evt;
  endsequence

  AST_BLANK_OFF: assert property (
    blank_on |=> core_r.gs_cnt == GS_ZERO && core_r.sink == '0)
    else $error("outputs off did not clear counter and sinks");

  AST_BLANK_COPY: assert property (
    blank_on |=> core_r.ctrl2 == $past(core_r.ctrl1[CTRL2_W-1:0]))
    else $error("second latch not refreshed while off");

  AST_BRIGHT_SRC: assert property (
    $changed(global_brightness) |->
      $past(blank_on) || $past(wrap) || $past(restart_evt))
    else $error("brightness changed without latch transfer");

  AST_CTRL_LOAD: assert property (
    ctrl_write |=> core_r.ctrl1 == $past(link_r.shreg[CTRL1_W-1:0]))
    else $error("control latch not loaded on strobe");

  AST_ONE_PERIOD: assert property (
    wrap && !blank_on && !restart_evt && !core_r.ctrl1[RPT_POS]
      |=> core_r.disp == DISP_STOP ##1 core_r.sink == '0)
    else $error("single period did not stop");

  AST_REPEAT: assert property (
    wrap && !blank_on && !restart_evt && core_r.ctrl1[RPT_POS]
      |=> core_r.disp == DISP_RUN && core_r.gs_cnt == GS_ZERO)
    else $error("repeat did not restart period");

  AST_RESTART: assert property (
    s_restart |=> s_cleared)
    else $error("timing restart did not clear");

  AST_NO_RESTART: assert property (
    gs_write && !core_r.ctrl1[RST_POS] && !blank_on && !gs_rise &&
      core_r.disp == DISP_RUN |=> $stable(core_r.gs_cnt))
    else $error("strobe disturbed counter without restart");

  AST_RESUME: assert property (
    s_first_edge |=> core_r.gs_cnt == 16'h0001 && core_r.sink == $past(pwm_hit))
    else $error("pwm did not resume on next grayscale edge");

  AST_ADVANCE: assert property (
    core_r.disp == DISP_RUN && gs_rise && !wrap && !blank_on &&
      !restart_evt |=> core_r.gs_cnt == $past(core_r.gs_cnt) + 16'h0001)
    else $error("counter did not advance");

  AST_ONCE: assert property (
    core_r.capture && $past(once_only) |-> $past(core_r.fresh))
    else $error("capture repeated without new data");

  // second grayscale latch follows the first while off
  AST_GS_COPY: assert property (
    blank_on |=> core_r.gs2 == $past(core_r.gs1))
    else $error("grayscale second latch not refreshed while off");

  // sinks stand between grayscale edges
  AST_SINK_HOLD: assert property (
    core_r.disp == DISP_RUN && !gs_rise && !blank_on && !restart_evt
      |=> $stable(core_r.sink))
    else $error("sinks changed without a grayscale edge");

  // each grayscale edge before the wrap shows the compare at the old count
  AST_SINK_FOLLOW: assert property (
    core_r.disp == DISP_RUN && gs_rise && !wrap && !blank_on &&
      !restart_evt |=> core_r.sink == $past(pwm_hit))
    else $error("sinks did not follow the compare");

  // capture pulse only at the chosen count
  AST_CAPTURE_AT: assert property (
    core_r.capture |-> $past(gs_rise) &&
      $past(core_r.gs_cnt) == capture_point($past(fault_sample_timing)))
    else $error("fault capture at the wrong count");

  // off or restart marks new data for capture
  AST_FRESH_SET: assert property (
    blank_on || restart_evt |=> core_r.fresh)
    else $error("new data not marked for capture");

  // stopped display keeps sinks off
  AST_STOP_HOLD: assert property (
    core_r.disp == DISP_STOP && !blank_on && !restart_evt
      |=> core_r.disp == DISP_STOP && core_r.sink == '0)
    else $error("stopped display drove the sinks");

  AST_SHIFT: assert property (
    @(posedge shift_clock) disable iff (sys_rst)
    !$past(sys_rst) |-> link_r.shreg[SHIFT_W-1:1] ==
      $past(link_r.shreg[SHIFT_W-2:0]))
    else $error("shift register did not shift");

endmodule : led_driver_control_latch

// >>> testbench/led_ctrl_partner.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// display controller model: serial frames and load strobe
// ----------------------------------------------------------------
module led_ctrl_partner (
  output logic shift_clock,  // link clock, idle low
  output logic serial_in,    // serial data
  output logic load_strobe   // latch strobe
);
  // idle levels at time zero
  initial begin
    shift_clock = 1'b0;
    serial_in   = 1'b0;
    load_strobe = 1'b0;
  end
  // whole frame msb first, then strobe; clock stops between frames
  task automatic send_frame(input logic [256:0] f);
    int i;
    #7;
    for (i = 256; i >= 0; i--) begin
      serial_in = f[i];
      #16 shift_clock = 1'b1;
      #16 shift_clock = 1'b0;
    end
    serial_in = ~f[0];  // no stale bit between frames
    #50 load_strobe = 1'b1;
    #160 load_strobe = 1'b0;
    #400;  // quiet gap before the next frame
  endtask : send_frame
endmodule : led_ctrl_partner

// >>> testbench/led_driver_control_latch_bench.sv
`timescale 1ns/10ps
module led_driver_control_latch_bench;
  import led_latch_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [DC_W-1:0] DC_PAT = 112'h0123456789abcdeffedcba987654;
  logic               clock, sys_rst, gs;        // bench driven
  logic               shift_clock, serial_in, load_strobe, serial_out;
  logic [CH_N-1:0]    sink_outputs, exp_mask;    // sinks, expectation
  logic [BRIGHT_W-1:0] global_brightness;
  logic [DC_W-1:0]    dot_correction;
  logic               spread_mode_sel, fault_capture;
  logic [SEL_W-1:0]   open_threshold_sel, short_threshold_sel, fault_sample_timing;
  logic [PSAVE_W-1:0] power_save_sel;
  int                 num_errors, check_count, k, n;
  int                 cap_count;                 // capture pulses seen
  // ----------------------------------------------------------------
  // design, far side, clock
  // ----------------------------------------------------------------
  led_driver_control_latch dut (.clock(clock), .sys_rst(sys_rst),
    .shift_clock(shift_clock), .serial_in(serial_in), .load_strobe(load_strobe),
    .grayscale_clock(gs), .serial_out(serial_out), .sink_outputs(sink_outputs),
    .global_brightness(global_brightness), .dot_correction(dot_correction),
    .spread_mode_sel(spread_mode_sel), .open_threshold_sel(open_threshold_sel),
    .short_threshold_sel(short_threshold_sel),
    .fault_sample_timing(fault_sample_timing), .power_save_sel(power_save_sel),
    .fault_capture(fault_capture));
  led_ctrl_partner ctl (.shift_clock(shift_clock), .serial_in(serial_in),
    .load_strobe(load_strobe));
  initial clock = 1'b0;
  always #20 clock = ~clock;  // 25 MHz
  // count one-cycle capture pulses while they stand
  always @(negedge clock) if (fault_capture === 1'b1) cap_count++;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare and count
  task automatic check_val(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check_val
  task automatic tick(input int c);
    repeat (c) @(negedge clock);
  endtask : tick
  // one grayscale period of eight system clocks
  task automatic gs_pulse();
    gs = 1'b1;
    tick(4);
    gs = 1'b0;
    tick(4);
  endtask : gs_pulse
  task automatic put(input logic [256:0] f);
    ctl.send_frame(f);
    tick(2);
  endtask : put
  // control frame; fl = {style, restart, repeat, off}
  function automatic logic [256:0] ctrl_frame(input logic [6:0] br, input logic [3:0] fl,
      input logic [1:0] op, input logic [1:0] sh, input logic [1:0] sm);
    logic [256:0] f;
    f = '0;
    f[SHIFT_MSB] = 1'b1;
    f[DC_W-1:0] = DC_PAT;
    f[BRIGHT_LO +: BRIGHT_W] = br;
    f[BLANK_POS +: 4] = fl;
    f[OPEN_LO +: SEL_W] = op;
    f[SHORT_LO +: SEL_W] = sh;
    f[SAMPLE_LO +: SEL_W] = sm;
    f[PSAVE_LO +: PSAVE_W] = 3'h5;
    return f;
  endfunction : ctrl_frame
  // grayscale frame; channel n gets base, or n when inc is set
  function automatic logic [256:0] gs_frame(input logic [15:0] base, input logic inc);
    logic [256:0] f;
    int c;
    f = '0;
    for (c = 0; c < CH_N; c++) f[16*c +: 16] = inc ? c[15:0] : base;
    return f;
  endfunction : gs_frame
  // verdict and end of run
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    gs = 1'b0;
    num_errors = 0;
    check_count = 0;
    tick(5);
    sys_rst = 1'b0;
    tick(2);
    check_val(power_save_sel, 3'h7);
    check_val(sink_outputs, 16'h0000);
    gs_pulse();
    check_val(sink_outputs, 16'h0000);
    // blanked write: fields land, second latch follows
    put(ctrl_frame(7'h55, 4'h1, 2'h1, 2'h2, 2'h3));
    check_val(serial_out, 1'b1);
    check_val(global_brightness, 7'h55);
    check_val(dot_correction, DC_PAT);
    check_val(power_save_sel, 3'h5);
    put(gs_frame(16'h0000, 1'b1));
    check_val(serial_out, 1'b0);
    // outputs on, conventional, no repeat, no restart
    put(ctrl_frame(7'h2a, 4'h0, 2'h2, 2'h1, 2'h0));
    for (k = 0; k < 17; k++) begin
      gs_pulse();
      for (n = 0; n < CH_N; n++) exp_mask[n] = (k < n);
      check_val(sink_outputs, exp_mask);
    end
    check_val(cap_count, 1);
    check_val(global_brightness, 7'h55);
    // strobe without restart leaves the count running
    put(gs_frame(16'hffff, 1'b0));
    gs_pulse();
    check_val(sink_outputs, 16'h0000);
    // restart on grayscale write
    put(ctrl_frame(7'h2a, 4'h4, 2'h2, 2'h1, 2'h0));
    put(gs_frame(16'hffff, 1'b0));
    check_val(global_brightness, 7'h2a);
    gs_pulse();
    check_val(sink_outputs, 16'hffff);
    // spread style, restart and repeat: sinks forced off at the strobe
    put(ctrl_frame(7'h2a, 4'he, 2'h2, 2'h1, 2'h0));
    check_val(spread_mode_sel, 1'b1);
    put(gs_frame(16'h0002, 1'b0));
    check_val(sink_outputs, 16'h0000);
    gs_pulse();
    check_val(sink_outputs, 16'hffff);
    gs_pulse();
    check_val(sink_outputs, 16'h0000);
    check_val(cap_count, 2);
    // outputs off again, every selector code
    for (k = 0; k < 4; k++) begin
      put(ctrl_frame(7'h11, 4'h1, k[1:0], 2'h3 - k[1:0], k[1:0]));
      check_val(open_threshold_sel, k[1:0]);
      check_val(short_threshold_sel, 2'h3 - k[1:0]);
      check_val(fault_sample_timing, k[1:0]);
    end
    check_val(spread_mode_sel, 1'b0);
    check_val(global_brightness, 7'h11);
    gs_pulse();
    check_val(sink_outputs, 16'h0000);
    wrap_up();
  end
endmodule : led_driver_control_latch_bench
